// >>> src/dpc_defines.vh
// register offsets, field positions and reset values of the dual pwm/capture timer
// assumes: included by bare name from design files under src/
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

// ==========================================
// register byte offsets
`define DPC_OFS_PRESCALE   12'h000
`define DPC_OFS_DIVSEL     12'h004
`define DPC_OFS_CTRL       12'h008
`define DPC_OFS_PERIOD0    12'h00C
`define DPC_OFS_THRESH0    12'h010
`define DPC_OFS_COUNT0     12'h014
`define DPC_OFS_PERIOD1    12'h018
`define DPC_OFS_THRESH1    12'h01C
`define DPC_OFS_COUNT1     12'h020
`define DPC_OFS_IRQEN      12'h040
`define DPC_OFS_IRQFLAG    12'h044
`define DPC_OFS_LATCHCTRL  12'h050
`define DPC_OFS_RISE0      12'h058
`define DPC_OFS_FALL0      12'h05C
`define DPC_OFS_RISE1      12'h060
`define DPC_OFS_FALL1      12'h064
`define DPC_OFS_LATCHINEN  12'h078
`define DPC_OFS_OUTEN      12'h07C

// ==========================================
// field positions
`define DPC_PRESCALE_LSB   0
`define DPC_GAP_LSB        16
`define DPC_DIV0_LSB       0
`define DPC_DIV1_LSB       4
`define DPC_CTRL_RUN0      0
`define DPC_CTRL_MODE0     1
`define DPC_CTRL_RUN1      8
`define DPC_CTRL_MODE1     9
`define DPC_CTRL_PAIR      16
`define DPC_LC_EN0         0
`define DPC_LC_RISEIE0     1
`define DPC_LC_FALLIE0     2
`define DPC_LC_FLAG0       4
`define DPC_LC_EN1         16
`define DPC_LC_RISEIE1     17
`define DPC_LC_FALLIE1     18
`define DPC_LC_FLAG1       20

// ==========================================
// reset values and selector codes
`define DPC_RESET_WORD     32'h0000_0000
`define DPC_SEL_DIV1       3'h4

`endif

// >>> src/dpc_timer.v
// one channel: 16-bit period down-counter with double-buffered period and threshold
// assumes: tick is a one-cycle pulse on sys_clk, one per count unit
`timescale 1ns/1ns
module dpc_timer #(
	parameter WIDTH = 16
) (
	input  wire             sys_clk,       // system clock
	input  wire             rst_n,         // async reset, active low
	input  wire             tick,          // count unit pulse
	input  wire             runEnable,     // counter_run_enable
	input  wire             reloadMode,    // reload_mode_select
	input  wire [WIDTH-1:0] periodShadow,  // software period value
	input  wire [WIDTH-1:0] threshShadow,  // software duty_threshold value
	input  wire             captureReload, // reload request from capture
	output reg  [WIDTH-1:0] count,         // live down-counter
	output reg              level,         // pwm level
	output reg              zeroEvent      // one-cycle pulse at zero
);
	reg             running;
	reg             halted;
	reg [WIDTH-1:0] activeThresh;

	// ==========================================
	// counting
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count        <= 16'h0000;
			running      <= 1'b0;
			halted       <= 1'b0;
			activeThresh <= 16'h0000;
			level        <= 1'b0;
			zeroEvent    <= 1'b0;
		end else begin
			zeroEvent <= 1'b0;
			if (!runEnable) begin
				running <= 1'b0;
				halted  <= 1'b0;
			end else if (!running && !halted) begin
				running      <= 1'b1;
				count        <= periodShadow;
				activeThresh <= threshShadow;
			end else if (running && captureReload) begin
				count <= periodShadow;
			end else if (running && tick) begin
				if (count == 16'h0000) begin
					zeroEvent    <= 1'b1;
					activeThresh <= threshShadow;
					if (reloadMode && periodShadow != 16'h0000) begin
						count <= periodShadow;
					end else begin
						running <= 1'b0;
						halted  <= 1'b1;
					end
				end else begin
					count <= count - 16'h0001;
				end
			end
			// high while count is at or below the threshold: cmp+1 units high per cycle
			if (running) begin
				level <= (count <= activeThresh);
			end
		end
	end
endmodule

// >>> src/dpc_deadzone.v
// dead-zone pair: complementary outputs with a gap before each rising edge
// assumes: unitTick is the selector 0 count unit pulse
`timescale 1ns/1ns
module dpc_deadzone (
	input  wire       sys_clk,   // system clock
	input  wire       rst_n,     // async reset, active low
	input  wire       unitTick,  // gap time unit
	input  wire [7:0] gapLength, // gap_length in units
	input  wire       source,    // timer 0 level
	output reg        outA,      // follows source
	output reg        outB       // complement of source
);
	reg       lastSource;
	reg [7:0] gapCount;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastSource <= 1'b0;
			gapCount   <= 8'h00;
			outA       <= 1'b0;
			outB       <= 1'b0;
		end else begin
			lastSource <= source;
			if (source != lastSource) begin
				gapCount <= gapLength;
				outA     <= 1'b0;
				outB     <= 1'b0;
			end else if (gapCount != 8'h00) begin
				if (unitTick) begin
					gapCount <= gapCount - 8'h01;
					// release on the gapLength-th tick after the source change, so the gap ends on a unit boundary
					if (gapCount == 8'h01) begin
						outA <= source;
						outB <= ~source;
					end
				end
			end else begin
				outA <= source;
				outB <= ~source;
			end
		end
	end
endmodule

// >>> src/dpc_top.v
// dual pwm generator / capture timer with apb register slave
// assumes: apb master on sys_clk; capture pins are asynchronous to sys_clk
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "dpc_defines.vh"
module dpc_top (
	input  wire        sys_clk,    // 20 MHz system clock
	input  wire        rst_n,      // async reset, active low
	input  wire        psel,       // apb select
	input  wire        penable,    // apb access phase
	input  wire        pwrite,     // apb direction
	input  wire [11:0] paddr,      // apb byte address
	input  wire [31:0] pwdata,     // apb write data
	output reg  [31:0] prdata,     // apb read data
	output reg         pready,     // apb ready
	output reg         pslverr,    // apb error on unmapped address
	input  wire [1:0]  pinIn,      // pin level in (capture)
	output reg  [1:0]  pinOut,     // pin level out (pwm)
	output reg  [1:0]  pinOe,      // pin output enable, high drives
	output reg         channel0Irq, // channel 0 interrupt
	output reg         channel1Irq, // channel 1 interrupt
	output reg         irq         // combined interrupt request
);
	// ==========================================
	// helpers
	function divTick;
		input [2:0] sel;
		input [3:0] cnt;
		input       pre;
		begin
			case (sel)
				3'h0:    divTick = pre & cnt[0];
				3'h1:    divTick = pre & (&cnt[1:0]);
				3'h2:    divTick = pre & (&cnt[2:0]);
				3'h3:    divTick = pre & (&cnt);
				3'h4:    divTick = pre;
				default: divTick = 1'b0;
			endcase
		end
	endfunction

	function mapped;
		input [11:0] a;
		begin
			case (a)
				`DPC_OFS_PRESCALE, `DPC_OFS_DIVSEL, `DPC_OFS_CTRL,
				`DPC_OFS_PERIOD0, `DPC_OFS_THRESH0, `DPC_OFS_COUNT0,
				`DPC_OFS_PERIOD1, `DPC_OFS_THRESH1, `DPC_OFS_COUNT1,
				`DPC_OFS_IRQEN, `DPC_OFS_IRQFLAG, `DPC_OFS_LATCHCTRL,
				`DPC_OFS_RISE0, `DPC_OFS_FALL0, `DPC_OFS_RISE1,
				`DPC_OFS_FALL1, `DPC_OFS_LATCHINEN, `DPC_OFS_OUTEN: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	// ==========================================
	// software registers
	reg  [7:0]  prescaleValue;
	reg  [7:0]  gapLength;
	reg  [2:0]  timer0DividerSelect;
	reg  [2:0]  timer1DividerSelect;
	reg  [1:0]  counterRunEnable;
	reg  [1:0]  reloadModeSelect;
	reg         pairDeadzoneEnable;
	reg  [15:0] periodShadow [0:1];
	reg  [15:0] threshShadow [0:1];
	reg  [1:0]  timerIrqEnable;
	reg  [1:0]  timerFlag;
	reg  [1:0]  latchEnable;
	reg  [1:0]  riseIrqEnable;
	reg  [1:0]  fallIrqEnable;
	reg  [1:0]  latchEventFlag;
	reg  [1:0]  latchInputEnable;
	reg  [1:0]  outputEnable;
	reg  [15:0] riseLatchValue [0:1];
	reg  [15:0] fallLatchValue [0:1];

	wire        wrStrobe = psel & penable & pready & pwrite;
	wire        rdSetup  = psel & ~penable;

	// ==========================================
	// clock generation
	reg  [7:0]  prescaleCount;
	reg         prescaleTick;
	reg  [3:0]  divCount;
	wire [1:0]  unitTick;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescaleCount <= 8'h00;
			prescaleTick  <= 1'b0;
			divCount      <= 4'h0;
		end else begin
			prescaleTick <= 1'b0;
			if (prescaleValue == 8'h00) begin
				prescaleCount <= 8'h00;
			end else if (prescaleCount == prescaleValue) begin
				prescaleCount <= 8'h00;
				prescaleTick  <= 1'b1;
			end else begin
				prescaleCount <= prescaleCount + 8'h01;
			end
			if (prescaleTick) begin
				divCount <= divCount + 4'h1;
			end
		end
	end

	// the shared divide counter means divided ticks stay phase-aligned between timers
	assign unitTick[0] = divTick(timer0DividerSelect, divCount, prescaleTick);
	assign unitTick[1] = divTick(timer1DividerSelect, divCount, prescaleTick);

	// ==========================================
	// capture input synchronisers and edge detect
	reg  [1:0]  capSync1;
	reg  [1:0]  capSync2;
	reg  [1:0]  capLast;
	wire [1:0]  capActive = latchEnable & latchInputEnable;
	wire [1:0]  riseEdge  = capActive & capSync2 & ~capLast;
	wire [1:0]  fallEdge  = capActive & ~capSync2 & capLast;
	wire [1:0]  capEvent  = (riseEdge & riseIrqEnable) | (fallEdge & fallIrqEnable);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			capSync1 <= 2'b00;
			capSync2 <= 2'b00;
			capLast  <= 2'b00;
		end else begin
			capSync1 <= pinIn;
			capSync2 <= capSync1;
			capLast  <= capSync2;
		end
	end

	// ==========================================
	// timers
	wire [15:0] liveCount [0:1];
	wire [1:0]  level;
	wire [1:0]  zeroEvent;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : chan
			dpc_timer #(.WIDTH(16)) u_timer (
				.sys_clk       (sys_clk),
				.rst_n         (rst_n),
				.tick          (unitTick[gi]),
				.runEnable     (counterRunEnable[gi]),
				.reloadMode    (reloadModeSelect[gi]),
				.periodShadow  (periodShadow[gi]),
				.threshShadow  (threshShadow[gi]),
				.captureReload (capEvent[gi]),
				.count         (liveCount[gi]),
				.level         (level[gi]),
				.zeroEvent     (zeroEvent[gi])
			);

			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					riseLatchValue[gi] <= 16'h0000;
					fallLatchValue[gi] <= 16'h0000;
				end else begin
					if (riseEdge[gi]) begin
						riseLatchValue[gi] <= liveCount[gi];
					end
					if (fallEdge[gi]) begin
						fallLatchValue[gi] <= liveCount[gi];
					end
				end
			end
		end
	endgenerate

	wire        pairA;
	wire        pairB;

	dpc_deadzone u_deadzone (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.unitTick  (unitTick[0]),
		.gapLength (gapLength),
		.source    (level[0]),
		.outA      (pairA),
		.outB      (pairB)
	);

	// ==========================================
	// pins and interrupts
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinOut      <= 2'b00;
			pinOe       <= 2'b00;
			channel0Irq <= 1'b0;
			channel1Irq <= 1'b0;
			irq         <= 1'b0;
		end else begin
			pinOut      <= pairDeadzoneEnable ? {pairB, pairA} : level;
			pinOe       <= outputEnable & ~latchEnable;
			channel0Irq <= (timerFlag[0] & timerIrqEnable[0]) | latchEventFlag[0];
			channel1Irq <= (timerFlag[1] & timerIrqEnable[1]) | latchEventFlag[1];
			irq         <= channel0Irq | channel1Irq;
		end
	end

	// ==========================================
	// register writes; hardware set wins over write-one-to-clear
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescaleValue       <= 8'h00;
			gapLength           <= 8'h00;
			timer0DividerSelect <= 3'h0;
			timer1DividerSelect <= 3'h0;
			counterRunEnable    <= 2'b00;
			reloadModeSelect    <= 2'b00;
			pairDeadzoneEnable  <= 1'b0;
			periodShadow[0]     <= 16'h0000;
			periodShadow[1]     <= 16'h0000;
			threshShadow[0]     <= 16'h0000;
			threshShadow[1]     <= 16'h0000;
			timerIrqEnable      <= 2'b00;
			timerFlag           <= 2'b00;
			latchEnable         <= 2'b00;
			riseIrqEnable       <= 2'b00;
			fallIrqEnable       <= 2'b00;
			latchEventFlag      <= 2'b00;
			latchInputEnable    <= 2'b00;
			outputEnable        <= 2'b00;
		end else begin
			if (wrStrobe) begin
				case (paddr)
					`DPC_OFS_PRESCALE: begin
						prescaleValue <= pwdata[`DPC_PRESCALE_LSB+7:`DPC_PRESCALE_LSB];
						gapLength     <= pwdata[`DPC_GAP_LSB+7:`DPC_GAP_LSB];
					end
					`DPC_OFS_DIVSEL: begin
						timer0DividerSelect <= pwdata[`DPC_DIV0_LSB+2:`DPC_DIV0_LSB];
						timer1DividerSelect <= pwdata[`DPC_DIV1_LSB+2:`DPC_DIV1_LSB];
					end
					`DPC_OFS_CTRL: begin
						counterRunEnable   <= {pwdata[`DPC_CTRL_RUN1], pwdata[`DPC_CTRL_RUN0]};
						reloadModeSelect   <= {pwdata[`DPC_CTRL_MODE1], pwdata[`DPC_CTRL_MODE0]};
						pairDeadzoneEnable <= pwdata[`DPC_CTRL_PAIR];
					end
					`DPC_OFS_PERIOD0:   periodShadow[0] <= pwdata[15:0];
					`DPC_OFS_THRESH0:   threshShadow[0] <= pwdata[15:0];
					`DPC_OFS_PERIOD1:   periodShadow[1] <= pwdata[15:0];
					`DPC_OFS_THRESH1:   threshShadow[1] <= pwdata[15:0];
					`DPC_OFS_IRQEN:     timerIrqEnable  <= pwdata[1:0];
					`DPC_OFS_LATCHCTRL: begin
						latchEnable   <= {pwdata[`DPC_LC_EN1], pwdata[`DPC_LC_EN0]};
						riseIrqEnable <= {pwdata[`DPC_LC_RISEIE1], pwdata[`DPC_LC_RISEIE0]};
						fallIrqEnable <= {pwdata[`DPC_LC_FALLIE1], pwdata[`DPC_LC_FALLIE0]};
					end
					`DPC_OFS_LATCHINEN: latchInputEnable <= pwdata[1:0];
					`DPC_OFS_OUTEN:     outputEnable     <= pwdata[1:0];
					default: begin
					end
				endcase
			end
			timerFlag <= (timerFlag
				& ~((wrStrobe && paddr == `DPC_OFS_IRQFLAG) ? pwdata[1:0] : 2'b00))
				| zeroEvent;
			latchEventFlag <= (latchEventFlag
				& ~((wrStrobe && paddr == `DPC_OFS_LATCHCTRL)
					? {pwdata[`DPC_LC_FLAG1], pwdata[`DPC_LC_FLAG0]} : 2'b00))
				| capEvent;
		end
	end

	// ==========================================
	// apb read and response, data registered in the setup cycle
	reg [31:0] next_prdata;

	always @* begin
		next_prdata = `DPC_RESET_WORD;
		case (paddr)
			`DPC_OFS_PRESCALE:  next_prdata = {8'h00, gapLength, 8'h00, prescaleValue};
			`DPC_OFS_DIVSEL:    next_prdata = {25'h000_0000, timer1DividerSelect,
				1'b0, timer0DividerSelect};
			`DPC_OFS_CTRL:      next_prdata = {15'h0000, pairDeadzoneEnable, 6'h00,
				reloadModeSelect[1], counterRunEnable[1], 6'h00,
				reloadModeSelect[0], counterRunEnable[0]};
			`DPC_OFS_PERIOD0:   next_prdata = {16'h0000, periodShadow[0]};
			`DPC_OFS_THRESH0:   next_prdata = {16'h0000, threshShadow[0]};
			`DPC_OFS_COUNT0:    next_prdata = {16'h0000, liveCount[0]};
			`DPC_OFS_PERIOD1:   next_prdata = {16'h0000, periodShadow[1]};
			`DPC_OFS_THRESH1:   next_prdata = {16'h0000, threshShadow[1]};
			`DPC_OFS_COUNT1:    next_prdata = {16'h0000, liveCount[1]};
			`DPC_OFS_IRQEN:     next_prdata = {30'h0000_0000, timerIrqEnable};
			`DPC_OFS_IRQFLAG:   next_prdata = {30'h0000_0000, timerFlag};
			`DPC_OFS_LATCHCTRL: next_prdata = {11'h000, latchEventFlag[1], 1'b0,
				fallIrqEnable[1], riseIrqEnable[1], latchEnable[1], 11'h000,
				latchEventFlag[0], 1'b0, fallIrqEnable[0], riseIrqEnable[0],
				latchEnable[0]};
			`DPC_OFS_RISE0:     next_prdata = {16'h0000, riseLatchValue[0]};
			`DPC_OFS_FALL0:     next_prdata = {16'h0000, fallLatchValue[0]};
			`DPC_OFS_RISE1:     next_prdata = {16'h0000, riseLatchValue[1]};
			`DPC_OFS_FALL1:     next_prdata = {16'h0000, fallLatchValue[1]};
			`DPC_OFS_LATCHINEN: next_prdata = {30'h0000_0000, latchInputEnable};
			`DPC_OFS_OUTEN:     next_prdata = {30'h0000_0000, outputEnable};
			default:            next_prdata = `DPC_RESET_WORD;
		endcase
	end

	// zero wait states: pready stays high once out of reset
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= `DPC_RESET_WORD;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (rdSetup) begin
				prdata  <= pwrite ? `DPC_RESET_WORD : next_prdata;
				pslverr <= ~mapped(paddr);
			end
		end
	end
endmodule

// >>> tb/dpc_checker.sv
// checker: apb answers, pin and interrupt relations of the pwm/capture top
// assumes: bound to dpc_top; register state is shadowed from observed apb writes
`timescale 1ns/1ns
`include "dpc_defines.vh"
module dpc_checker (
	input wire        sys_clk,     // clock
	input wire        rst_n,       // async reset
	input wire        psel,        // apb select
	input wire        penable,     // apb access
	input wire        pwrite,      // apb direction
	input wire [11:0] paddr,       // apb address
	input wire [31:0] pwdata,      // apb write data
	input wire [31:0] prdata,      // apb read data
	input wire        pready,      // apb ready
	input wire        pslverr,     // apb error
	input wire [1:0]  pinIn,       // pin level in
	input wire [1:0]  pinOut,      // pin level out
	input wire [1:0]  pinOe,       // pin drive enable
	input wire        channel0Irq, // channel 0 irq
	input wire        channel1Irq, // channel 1 irq
	input wire        irq          // combined irq
);
	// ==========================================
	// register shadows
	reg  [31:0] ctrl;
	reg  [31:0] lc;
	reg  [1:0]  inEn;
	reg  [1:0]  ie;
	wire        wr      = psel && penable && pready && pwrite;
	wire        aligned = paddr[1:0] == 2'b00;
	wire        mapped  = aligned && (paddr <= 12'h020 || (paddr >= 12'h058 && paddr <= 12'h064)
	                      || paddr == 12'h040 || paddr == 12'h044 || paddr == 12'h050
	                      || paddr == 12'h078 || paddr == 12'h07C);
	wire [1:0]  capOn   = {lc[16] & inEn[1], lc[0] & inEn[0]};
	wire        idle0   = !ctrl[0] && !ctrl[16];
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 32'h0000_0000;
			lc   <= 32'h0000_0000;
			inEn <= 2'b00;
			ie   <= 2'b00;
		end else if (wr) begin
			if (paddr == `DPC_OFS_CTRL)
				ctrl <= pwdata;
			if (paddr == `DPC_OFS_LATCHCTRL)
				lc <= pwdata;
			if (paddr == `DPC_OFS_LATCHINEN)
				inEn <= pwdata[1:0];
			if (paddr == `DPC_OFS_IRQEN)
				ie <= pwdata[1:0];
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================
	// assertions
	a_irq_merge: assert property ((channel0Irq || channel1Irq) |=> irq)
		else $error("combined irq missing");
	a_irq_clear: assert property (!(channel0Irq || channel1Irq) |=> !irq)
		else $error("combined irq without source");
	a_unmapped_err: assert property (psel && penable && aligned && !mapped |-> pslverr)
		else $error("no error on unmapped address");
	a_unmapped_zero: assert property (psel && penable && !pwrite && aligned && !mapped
		|-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_capture_input: assert property ((capOn & $past(capOn) & pinOe) == 2'b00)
		else $error("capture pin still driven");
	a_pair_apart: assert property (ctrl[16] && $past(ctrl[16], 2) |-> !(pinOut[0] && pinOut[1]))
		else $error("paired outputs high together");
	a_irq0_source: assert property ($rose(channel0Irq) |-> ie[0] || lc[1] || lc[2])
		else $error("channel 0 irq while disabled");
	a_irq1_source: assert property ($rose(channel1Irq) |-> ie[1] || lc[17] || lc[18])
		else $error("channel 1 irq while disabled");
	a_stopped_frozen: assert property (idle0 [*4] |=> $stable(pinOut[0]))
		else $error("stopped channel output moved");
	c_refused: cover property (psel && penable && pslverr);
	c_pair_high: cover property (ctrl[16] && pinOut[1]);
	c_irq1: cover property ($rose(channel1Irq));
endmodule
bind dpc_top dpc_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
	.channel0Irq(channel0Irq), .channel1Irq(channel1Irq), .irq(irq));

// >>> tb/dpc_pin_src.sv
// pulse source on the two timer pins
// assumes: drive is set by the bench just after a clock edge
`timescale 1ns/1ns
module dpc_pin_src (
	input  wire [1:0] drive,  // commanded source level
	input  wire [1:0] pinOut, // timer pin level
	input  wire [1:0] pinOe,  // timer drive enable
	output wire [1:0] pinIn   // resolved pin level
);
	// the source only wins once the timer has released the pin
	assign pinIn = (pinOe & pinOut) | (~pinOe & drive);
endmodule

// >>> tb/test_dpc_top.sv
// self-checking bench for the pwm/capture top over apb
// assumes: dpc_top ports, offsets from dpc_defines.vh, 20 MHz clock
`timescale 1ns/1ns
`include "dpc_defines.vh"
module test_dpc_top;
	reg         sys_clk = 1'b0;
	reg         rst_n   = 1'b0;
	reg         psel    = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite  = 1'b0;
	reg  [11:0] paddr   = 12'h000;
	reg  [31:0] pwdata  = 32'h0000_0000;
	reg  [1:0]  drive   = 2'b00;
	reg  [31:0] rd;
	reg  [31:0] rd2;
	reg         err;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        ch0Irq;
	wire        ch1Irq;
	wire        irq;
	wire [1:0]  pinIn;
	wire [1:0]  pinOut;
	wire [1:0]  pinOe;
	integer     miscompares = 0;
	integer     n_tests = 0;
	integer     cyc = 0;
	integer     hiW;
	integer     loW;
	integer     i;
	dpc_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.channel0Irq(ch0Irq), .channel1Irq(ch1Irq), .irq(irq));
	dpc_pin_src u_src (.drive(drive), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
	always #25 sys_clk = ~sys_clk;
	// ==========================================
	// tasks
	task finish_test;
		begin
			$display("compares=%0d mismatches=%0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// the run is a few thousand cycles; the ceiling leaves a wide margin
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			finish_test();
		end
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge sys_clk);
			penable <= 1'b1;
			@(posedge sys_clk);
			// no wait-state count is assumed: only the bench timeout ends this wait
			while (pready !== 1'b1)
				@(posedge sys_clk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task run(input integer ch, input lvl, output integer n);
		begin
			n = 0;
			while (pinOut[ch] === lvl && n < 3000) begin
				@(posedge sys_clk);
				n = n + 1;
			end
		end
	endtask
	// skips the running pulse, then times one whole high and low phase in clocks
	task meas(input integer ch);
		integer d;
		begin
			run(ch, 1'b1, d);
			run(ch, 1'b0, d);
			run(ch, 1'b1, hiW);
			run(ch, 1'b0, loW);
		end
	endtask
	// ==========================================
	// test sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		apb(1'b1, 12'h030, 32'hFFFF_FFFF);
		check(err, 1'b1);
		apb(1'b0, 12'h030, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b1, `DPC_OFS_COUNT0, 32'hFFFF_FFFF);
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		check(rd, `DPC_RESET_WORD);
		$display("[TEST] bus done");
		apb(1'b1, `DPC_OFS_DIVSEL, 32'h0000_0044);
		apb(1'b1, `DPC_OFS_THRESH0, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_PERIOD0, 32'h0000_0009);
		apb(1'b1, `DPC_OFS_OUTEN, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0003);
		repeat (10) @(posedge sys_clk);
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		check(rd, 32'h0000_0009);
		apb(1'b1, `DPC_OFS_PRESCALE, 32'h0000_0001);
		meas(0);
		check(hiW, 8);
		check(loW, 12);
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		rd2 = rd;
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		check(rd != rd2 && rd <= 9, 1'b1);
		apb(1'b1, `DPC_OFS_THRESH0, 32'h0000_0006);
		meas(0);
		meas(0);
		check(hiW, 14);
		check(loW, 6);
		apb(1'b1, `DPC_OFS_THRESH0, 32'h0000_0009);
		repeat (50) @(posedge sys_clk);
		hiW = 0;
		repeat (40) begin
			@(posedge sys_clk);
			hiW = hiW + pinOut[0];
		end
		check(hiW, 40);
		$display("[TEST] pwm done");
		apb(1'b1, `DPC_OFS_THRESH1, 32'h0000_0001);
		apb(1'b1, `DPC_OFS_PERIOD1, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0303);
		for (i = 0; i < 5; i = i + 1) begin
			apb(1'b1, `DPC_OFS_DIVSEL, 32'h0000_0004 | (i << 4));
			meas(1);
			meas(1);
			check(hiW + loW, (i == 4) ? 8 : (16 << i));
		end
		$display("[TEST] divider done");
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_IRQFLAG, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_IRQEN, 32'h0000_0002);
		apb(1'b1, `DPC_OFS_PERIOD1, 32'h0000_0005);
		check(ch1Irq, 1'b0);
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0103);
		for (i = 0; i < 300 && ch1Irq !== 1'b1; i = i + 1)
			@(posedge sys_clk);
		check(ch1Irq, 1'b1);
		@(posedge sys_clk);
		check(irq, 1'b1);
		apb(1'b0, `DPC_OFS_IRQFLAG, 32'h0000_0000);
		check(rd[1], 1'b1);
		apb(1'b1, `DPC_OFS_IRQFLAG, 32'h0000_0003);
		repeat (100) @(posedge sys_clk);
		apb(1'b0, `DPC_OFS_IRQFLAG, 32'h0000_0000);
		check(rd[1], 1'b0);
		check(ch1Irq, 1'b0);
		apb(1'b0, `DPC_OFS_COUNT1, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b1, `DPC_OFS_PERIOD0, 32'h0000_0000);
		repeat (60) @(posedge sys_clk);
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		rd2 = rd;
		repeat (10) @(posedge sys_clk);
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		check(rd | rd2, 32'h0000_0000);
		$display("[TEST] one-shot done");
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0000);
		apb(1'b1, `DPC_OFS_PRESCALE, 32'h0002_0001);
		apb(1'b1, `DPC_OFS_PERIOD0, 32'h0000_0009);
		apb(1'b1, `DPC_OFS_THRESH0, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_CTRL, 32'h0001_0003);
		repeat (40) @(posedge sys_clk);
		meas(0);
		check(hiW, 4);
		meas(1);
		check(hiW, 8);
		check(hiW + loW, 20);
		$display("[TEST] pair done");
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0000);
		apb(1'b1, `DPC_OFS_PERIOD0, 32'h0000_00C8);
		apb(1'b1, `DPC_OFS_LATCHCTRL, 32'h0000_0003);
		apb(1'b1, `DPC_OFS_LATCHINEN, 32'h0000_0001);
		apb(1'b1, `DPC_OFS_CTRL, 32'h0000_0003);
		repeat (100) @(posedge sys_clk);
		check(pinOe, 2'b10);
		drive <= 2'b01;
		for (i = 0; i < 50 && ch0Irq !== 1'b1; i = i + 1)
			@(posedge sys_clk);
		check(ch0Irq, 1'b1);
		apb(1'b0, `DPC_OFS_COUNT0, 32'h0000_0000);
		check(rd >= 193 && rd <= 200, 1'b1);
		apb(1'b0, `DPC_OFS_RISE0, 32'h0000_0000);
		check(rd > 100 && rd < 200, 1'b1);
		apb(1'b0, `DPC_OFS_LATCHCTRL, 32'h0000_0000);
		check(rd[4], 1'b1);
		apb(1'b1, `DPC_OFS_LATCHCTRL, 32'h0000_0013);
		drive <= 2'b00;
		repeat (20) @(posedge sys_clk);
		apb(1'b0, `DPC_OFS_FALL0, 32'h0000_0000);
		check(rd >= 180 && rd < 200, 1'b1);
		apb(1'b0, `DPC_OFS_LATCHCTRL, 32'h0000_0000);
		check(rd[4], 1'b0);
		$display("[TEST] capture done");
		finish_test();
	end
endmodule
